// *** rtl/pcg_clock_generator.sv ***
// PLL clock generator: reference tracking, multiplier and control register
//
// Overview of operation
// RL1: The oscillator stage follows the input pin clock at its own rate.
// RL2: Crystal or external clock on the input pin are both accepted.
// RL3: Multiplier select 0 (reset) gives four times, 1 gives eight times.
// RL4: The peripheral clock is always twice the input clock.
// RL5: The system clock output pin carries the peripheral clock.
// RL6: Internal clock feeds bus masters, peripheral clock the peripherals.
// RL7: The source keeps the input clock between 5 and 10 MHz.
// RL8: No clocks are produced in software or hardware standby.
// RL9: Power-on reset loads the control register with 01.
// RL10: Register is 8 bits: select, three read-only zeros, four stop bits.
// RL11: A write lands only as a word access carrying the key in its top byte.
// RL12: Byte and long writes are ignored and the contents kept.
// RL13: Software reads the register with byte accesses only.
// RL14: Word writes go to the register address, reads act as ordinary.
// RL15: Software quiesces DMA, trace and interrupts around a select change.
// RL16: A wrong key leaves the register alone; switching makes no runt pulse.
`timescale 1ns/100ps
module pcg_clock_generator (
  // Clock and power-on reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Oscillator pins
  input  wire logic        CLOCK_INPUT_PIN,
  input  wire logic        CRYSTAL_PIN,
  // Standby requests
  input  wire logic        SOFTWARE_STANDBY,
  input  wire logic        HARDWARE_STANDBY,
  // Register port
  input  wire logic [31:0] REG_ADDR,
  input  wire logic [1:0]  REG_SIZE,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  // Generated clocks
  output logic             INTERNAL_CLOCK,
  output logic             PERIPHERAL_CLOCK,
  output logic             SYSTEM_CLOCK_OUTPUT,
  // Control and status
  output logic             INTERNAL_CLOCK_MULTIPLIER_SELECT,
  output logic      [3:0]  MODULE_STOP,
  output logic             CLOCK_LOCKED,
  output logic             CRYSTAL_SOURCE
);

  pcg_pkg::pcg_reg_s                  reg_q;
  pcg_pkg::pcg_reg_s                  reg_d;
  logic [7:0]                         rdata_q;
  logic [7:0]                         rdata_d;
  logic                               wr_hit;
  logic                               key_ok;
  logic                               rd_ok;
  logic                               in_q;
  logic                               rise;
  logic                               fall;
  logic [pcg_pkg::PERIOD_W-1:0]       cnt_q;
  logic [pcg_pkg::PERIOD_W-1:0]       cnt_d;
  logic [pcg_pkg::PERIOD_W-1:0]       period_q;
  logic [pcg_pkg::PERIOD_W-1:0]       period_d;
  pcg_pkg::pcg_lock_e                 lock_q;
  pcg_pkg::pcg_lock_e                 lock_d;
  logic                               crystal_pin_hi_q;
  logic                               crystal_pin_hi_d;
  logic                               crys_q;
  logic                               crys_d;
  logic                               mult_q;
  logic                               mult_d;
  logic                               standby;
  logic                               clear;
  logic [pcg_pkg::STEP_W-1:0]         int_step;
  logic                               int_clk;
  logic                               int_tog;
  logic                               per_clk;
  logic                               per_tog;

  // Register write and read decode
  always_comb begin
    wr_hit  = REG_WR && (REG_ADDR == pcg_pkg::REG_ADDR_MAIN)
              && (REG_SIZE == pcg_pkg::SIZE_WORD);            // see RL14 RL12
    key_ok  = REG_WDATA[15:8] == pcg_pkg::WRITE_KEY;           // see RL11 RL16
    rd_ok   = pcg_pkg::pcg_is_reg(REG_ADDR)
              && (REG_SIZE == pcg_pkg::SIZE_BYTE);
    reg_d   = reg_q;
    if (wr_hit && key_ok) begin
      reg_d.mult_sel = REG_WDATA[pcg_pkg::MULT_SEL_BIT];       // see RL11
      reg_d.rsvd     = 3'h0;                                  // see RL10
      reg_d.mstop    = REG_WDATA[pcg_pkg::MSTOP_MSB:pcg_pkg::MSTOP_LSB];
    end
    // Wider reads return zero rather than a torn image
    rdata_d = rdata_q;
    if (REG_RD) begin
      rdata_d = rd_ok ? reg_q : 8'h00;                        // see RL14
    end
  end

  // Register file, set to its reset value only by power-on reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      reg_q   <= pcg_pkg::REG_RESET;                          // see RL9
      rdata_q <= 8'h00;
    end else begin
      reg_q   <= reg_d;
      rdata_q <= rdata_d;
    end
  end

  // Oscillator stage edges; the pin is already in the CLK domain
  assign rise    = CLOCK_INPUT_PIN && !in_q;                  // see RL1
  assign fall    = !CLOCK_INPUT_PIN && in_q;
  assign standby = SOFTWARE_STANDBY || HARDWARE_STANDBY;

  // Period measurement, lock tracking and source detection
  always_comb begin
    cnt_d     = (cnt_q == '1) ? cnt_q : cnt_q + 16'h0001;
    period_d  = period_q;
    lock_d    = lock_q;
    crystal_pin_hi_d = crystal_pin_hi_q;
    crys_d    = crys_q;
    // A resonator drives the crystal pin in antiphase to the input pin
    if (fall) begin
      crystal_pin_hi_d = CRYSTAL_PIN;                                // see RL2
    end
    if (rise) begin
      cnt_d    = 16'h0001;
      period_d = cnt_q;                                       // see RL1
      crys_d   = crystal_pin_hi_q && !CRYSTAL_PIN;                   // see RL2
      case (lock_q)
        pcg_pkg::LK_IDLE:   lock_d = pcg_pkg::LK_FIRST;
        pcg_pkg::LK_FIRST:  lock_d = pcg_pkg::LK_LOCKED;
        pcg_pkg::LK_LOCKED: lock_d = pcg_pkg::LK_LOCKED;
        default:            lock_d = pcg_pkg::LK_IDLE;
      endcase
    end
    // Standby stops the generator; the reference is relearnt on exit
    if (standby) begin
      lock_d = pcg_pkg::LK_IDLE;                              // see RL8
    end
  end

  // Period, lock and source registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_q      <= 1'b0;
      cnt_q     <= '0;
      period_q  <= '1;
      lock_q    <= pcg_pkg::LK_IDLE;
      crystal_pin_hi_q <= 1'b0;
      crys_q    <= 1'b0;
    end else begin
      in_q      <= CLOCK_INPUT_PIN;
      cnt_q     <= cnt_d;
      period_q  <= period_d;
      lock_q    <= lock_d;
      crystal_pin_hi_q <= crystal_pin_hi_d;
      crys_q    <= crys_d;
    end
  end

  // Multiplier changes on a falling internal edge or while clear holds, never mid-pulse
  always_comb begin
    clear    = standby || (lock_q != pcg_pkg::LK_LOCKED);     // see RL8
    mult_d   = mult_q;
    if (clear || (int_tog && int_clk)) begin
      mult_d = reg_q.mult_sel;                                // see RL16
    end
    int_step = mult_q ? pcg_pkg::STEP_X8 : pcg_pkg::STEP_X4;  // see RL3
  end

  // Active multiplier
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mult_q <= 1'b0;
    end else begin
      mult_q <= mult_d;
    end
  end

  // Bus-master clock; CLK must be well above sixteen times the input
  pcg_nco u_int_nco (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .CLEAR   (clear),
    .STEP    (int_step),
    .PERIOD  (period_q),
    .CLK_OUT (int_clk),
    .TOGGLE  (int_tog)
  );

  // Peripheral clock, fixed at twice the input
  pcg_nco u_per_nco (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .CLEAR   (clear),
    .STEP    (pcg_pkg::STEP_PERIPH),                           // see RL4
    .PERIOD  (period_q),
    .CLK_OUT (per_clk),
    .TOGGLE  (per_tog)
  );

  // Output routing
  assign INTERNAL_CLOCK                   = int_clk;            // see RL6
  assign PERIPHERAL_CLOCK                 = per_clk;            // see RL6
  assign SYSTEM_CLOCK_OUTPUT              = per_clk;            // see RL5
  assign INTERNAL_CLOCK_MULTIPLIER_SELECT = mult_q;
  assign MODULE_STOP                      = reg_q.mstop;        // see RL10
  assign CLOCK_LOCKED                     = lock_q == pcg_pkg::LK_LOCKED;
  assign CRYSTAL_SOURCE                   = crys_q;
  assign REG_RDATA                        = rdata_q;

  // Toggle counts per input period, read only by the checks below
  logic [4:0] itog_q;
  logic [2:0] ptog_q;
  logic       win_q;
  logic       seen_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      itog_q <= 5'h00;
      ptog_q <= 3'h0;
      win_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
      if (rise) begin
        itog_q <= 5'h00;
        ptog_q <= 3'h0;
        win_q  <= CLOCK_LOCKED && !clear;
      end else begin
        itog_q <= itog_q + 5'(int_tog);
        ptog_q <= ptog_q + 3'(per_tog);
        if (clear || (mult_d != mult_q)) begin
          win_q <= 1'b0;
        end
      end
    end
  end

  sequence s_key_write;
    wr_hit && key_ok;
  endsequence

  sequence s_bad_write;
    REG_WR && !(wr_hit && key_ok);
  endsequence

  AST_KEY_WRITE: assert property (@(posedge CLK) disable iff (!RST_N) // see RL11
    s_key_write |=> reg_q == {$past(REG_WDATA[7]), 3'h0, $past(REG_WDATA[3:0])})
    else $error("keyed word write not stored");

  AST_BAD_WRITE: assert property (@(posedge CLK) disable iff (!RST_N) // see RL16
    s_bad_write ##0 !(REG_WR && REG_SIZE != pcg_pkg::SIZE_WORD) |=> $stable(reg_q))
    else $error("unkeyed word write changed register");

  AST_SIZE_WRITE: assert property (@(posedge CLK) disable iff (!RST_N) // see RL12
    REG_WR && (REG_SIZE != pcg_pkg::SIZE_WORD) |=> $stable(reg_q))
    else $error("byte or long write changed register");

  AST_RESET_VALUE: assert property (@(posedge CLK) disable iff (!RST_N) // see RL9
    !seen_q |-> reg_q == pcg_pkg::REG_RESET)
    else $error("register not 01 after reset");

  AST_READ_BACK: assert property (@(posedge CLK) disable iff (!RST_N) // see RL14
    REG_RD && rd_ok |=> REG_RDATA == $past(reg_q) && REG_RDATA[6:4] == 3'h0)
    else $error("byte read returned wrong data");

  AST_STANDBY_HALT: assert property (@(posedge CLK) disable iff (!RST_N) // see RL8
    standby |=> !INTERNAL_CLOCK && !PERIPHERAL_CLOCK && !CLOCK_LOCKED)
    else $error("clock ran in standby");

  AST_NO_RUNT: assert property (@(posedge CLK) disable iff (!RST_N) // see RL16
    $changed(mult_q) |-> !INTERNAL_CLOCK)
    else $error("multiplier switched while internal clock high");

  AST_MULT_RATE: assert property (@(posedge CLK) disable iff (!RST_N) // see RL3
    rise && win_q |-> (mult_q ? (itog_q >= 5'h0F && itog_q <= 5'h11)
                              : (itog_q >= 5'h07 && itog_q <= 5'h09)))
    else $error("internal clock rate off multiplier");

  AST_PERIPH_RATE: assert property (@(posedge CLK) disable iff (!RST_N) // see RL4
    rise && win_q |-> ptog_q >= 3'h3 && ptog_q <= 3'h5)
    else $error("peripheral clock not twice input");

endmodule : pcg_clock_generator

// *** rtl/pcg_nco.sv ***
// Phase accumulator that toggles a clock output at a measured rate
`timescale 1ns/100ps
module pcg_nco (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RST_N,
  // Control
  input  wire logic                         CLEAR,
  input  wire logic [pcg_pkg::STEP_W-1:0]   STEP,
  input  wire logic [pcg_pkg::PERIOD_W-1:0] PERIOD,
  // Output clock and toggle event
  output logic                              CLK_OUT,
  output logic                              TOGGLE
);

  logic [pcg_pkg::ACC_W-1:0] acc_q;
  logic [pcg_pkg::ACC_W-1:0] acc_d;
  logic [pcg_pkg::ACC_W-1:0] sum;
  logic                      out_q;
  logic                      out_d;
  logic                      hit;

  // Fractional stepping keeps the average rate exact for any period of at least STEP cycles
  always_comb begin
    sum    = acc_q + pcg_pkg::ACC_W'(STEP);
    hit    = sum >= {1'b0, PERIOD};
    acc_d  = hit ? sum - {1'b0, PERIOD} : sum;
    out_d  = out_q ^ hit;
    TOGGLE = hit && !CLEAR;
    if (CLEAR) begin
      acc_d = '0;
      out_d = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= '0;
      out_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      out_q <= out_d;
    end
  end

  assign CLK_OUT = out_q;

endmodule : pcg_nco

// *** rtl/pcg_pkg.sv ***
// Constants, field layout and types for the PLL clock generator
package pcg_pkg;

  // Register placement and write protection
  localparam logic [31:0] REG_ADDR_MAIN  = 32'hFFFFF70A;
  localparam logic [31:0] REG_ADDR_ALT   = 32'hFFFFF70B;
  localparam logic [7:0]  WRITE_KEY      = 8'h3C;
  localparam logic [7:0]  REG_RESET      = 8'h01;

  // Field positions inside the control register
  localparam int          MULT_SEL_BIT   = 7;
  localparam int          MSTOP_MSB      = 3;
  localparam int          MSTOP_LSB      = 0;

  // Access size codes on the register port
  localparam logic [1:0]  SIZE_BYTE      = 2'h0;
  localparam logic [1:0]  SIZE_WORD      = 2'h1;
  localparam logic [1:0]  SIZE_LONG      = 2'h2;

  // Period measurement and phase accumulator widths
  localparam int          PERIOD_W       = 16;
  localparam int          ACC_W          = 17;
  localparam int          STEP_W         = 5;

  // Toggles per input period: two per output cycle times the factor
  localparam logic [4:0]  STEP_X4        = 5'h08;
  localparam logic [4:0]  STEP_X8        = 5'h10;
  localparam logic [4:0]  STEP_PERIPH    = 5'h04;

  // Control register image
  typedef struct packed {
    logic       mult_sel;
    logic [2:0] rsvd;
    logic [3:0] mstop;
  } pcg_reg_s;

  // Reference lock tracking, Gray along the usual path
  typedef enum logic [1:0] {
    LK_IDLE   = 2'b00,
    LK_FIRST  = 2'b01,
    LK_LOCKED = 2'b11
  } pcg_lock_e;

  // Address match for the control register byte pair
  function automatic logic pcg_is_reg(input logic [31:0] addr);
    pcg_is_reg = (addr == REG_ADDR_MAIN) || (addr == REG_ADDR_ALT);
  endfunction : pcg_is_reg

endpackage : pcg_pkg

// *** verification/pcg_clock_generator_tb.sv ***
// Self-checking bench for the PLL clock generator
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module pcg_clock_generator_tb;
  localparam int HALF = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        xmode = 1'b1;
  logic        sw_stby = 1'b0;
  logic        hw_stby = 1'b0;
  logic [31:0] addr = 32'h00000000;
  logic [1:0]  size = 2'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic        ext_pin, crystal_pin_pin, iclk, pclk, sclk, msel, locked, xsrc;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic [3:0]  mstop;
  logic        pi = 1'b0, pp = 1'b0, pe = 1'b0;
  int          err_count = 0, checks_done = 0;
  int          ti = 0, tp = 0, tr = 0, sys_bad = 0, i0;

  // 25 MHz clock
  always #20 clk = ~clk;

  pcg_osc_model #(.HALF(HALF)) u_osc (.CLK(clk), .RUN(run),
    .CRYSTAL_PIN_MODE(xmode), .EXT_PIN(ext_pin), .CRYSTAL_PIN_PIN(crystal_pin_pin));

  pcg_clock_generator u_dut (.CLK(clk), .RST_N(rst_n),
    .CLOCK_INPUT_PIN(ext_pin), .CRYSTAL_PIN(crystal_pin_pin),
    .SOFTWARE_STANDBY(sw_stby), .HARDWARE_STANDBY(hw_stby),
    .REG_ADDR(addr), .REG_SIZE(size), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .INTERNAL_CLOCK(iclk),
    .PERIPHERAL_CLOCK(pclk), .SYSTEM_CLOCK_OUTPUT(sclk),
    .INTERNAL_CLOCK_MULTIPLIER_SELECT(msel), .MODULE_STOP(mstop),
    .CLOCK_LOCKED(locked), .CRYSTAL_SOURCE(xsrc));

  // Toggle and rise counters; the pin copy is compared every cycle
  always @(posedge clk) begin
    pi <= iclk;
    pp <= pclk;
    pe <= ext_pin;
    if (iclk !== pi) ti <= ti + 1;
    if (pclk !== pp) tp <= tp + 1;
    if (ext_pin === 1'b1 && pe === 1'b0) tr <= tr + 1;
    if (sclk !== pclk) sys_bad <= sys_bad + 1;
  end

  // Edge jitter of one toggle per period is allowed, two over a window
  function automatic int near(input int g, input int e);
    return (g >= e - 2 && g <= e + 2) ? e : g;
  endfunction : near

  task automatic reg_wr(input logic [31:0] a, input logic [1:0] s,
                        input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    size  <= s;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  // Strobe one cycle, data is there one edge after it is taken
  task automatic reg_rd(input logic [31:0] a, input logic [1:0] s);
    @(posedge clk);
    addr <= a;
    size <= s;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic wait_lock();
    int k;
    for (k = 0; k < 300 && locked !== 1'b1; k++) @(posedge clk);
    `CHK(locked, 1'b1)
  endtask : wait_lock

  // Toggles over n whole source periods, started on a source rise
  task automatic measure(input int n, input int ei, input int ep);
    int r0, p0, k;
    r0 = tr;
    for (k = 0; k < 400 && tr == r0; k++) @(posedge clk);
    r0 = tr;
    i0 = ti;
    p0 = tp;
    for (k = 0; k < 2000 && tr < r0 + n; k++) @(posedge clk);
    `CHK(near(ti - i0, ei), ei)
    `CHK(near(tp - p0, ep), ep)
  endtask : measure

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected run of just over a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // Register protection first, then clocks, then both standby kinds
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h01)
    `CHK(mstop, 4'h1)
    `CHK(msel, 1'b0)
    reg_wr(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_BYTE, 16'h3C8F);
    reg_rd(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h01)
    reg_wr(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_LONG, 16'h3C8F);
    reg_rd(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h01)
    reg_wr(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_WORD, 16'h5A8F);
    reg_rd(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h01)
    reg_wr(32'hFFFFF70C, pcg_pkg::SIZE_WORD, 16'h3C8F);
    reg_rd(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h01)
    reg_wr(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_WORD, 16'h3CFE);
    reg_rd(pcg_pkg::REG_ADDR_ALT, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h8E)
    `CHK(mstop, 4'hE)
    reg_rd(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_WORD);
    `CHK(d, 8'h00)
    reg_rd(32'hFFFFF700, pcg_pkg::SIZE_BYTE);
    `CHK(d, 8'h00)
    reg_wr(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_WORD, 16'h3C01);
    run <= 1'b1;
    wait_lock();
    measure(4, 32, 16);
    `CHK(xsrc, 1'b1)
    // Select change: no other bus traffic, then a quiet spell before use
    reg_wr(pcg_pkg::REG_ADDR_MAIN, pcg_pkg::SIZE_WORD, 16'h3C81);
    repeat (4 * HALF) @(posedge clk);
    `CHK(msel, 1'b1)
    measure(4, 64, 16);
    xmode <= 1'b0;
    measure(4, 64, 16);
    `CHK(xsrc, 1'b0)
    `CHK(sys_bad, 0)
    for (int k = 0; k < 2; k++) begin
      sw_stby <= (k == 0);
      hw_stby <= (k == 1);
      repeat (3) @(posedge clk);
      `CHK({iclk, pclk, locked}, 3'h0)
      i0 = ti;
      repeat (100) @(posedge clk);
      `CHK(ti - i0, 0)
      sw_stby <= 1'b0;
      hw_stby <= 1'b0;
      wait_lock();
    end
    complete_run();
  end
endmodule : pcg_clock_generator_tb

// *** verification/pcg_osc_model.sv ***
// Crystal or external clock source that feeds the generator input pins
`timescale 1ns/100ps
module pcg_osc_model #(
  parameter int HALF = 20
) (
  // Clock and source control
  input  wire logic CLK,
  input  wire logic RUN,
  input  wire logic CRYSTAL_PIN_MODE,
  // Oscillator pins
  output logic      EXT_PIN,
  output logic      CRYSTAL_PIN_PIN
);
  int   cnt_q = 0;
  logic ext_q = 1'b0;

  // Square wave, scaled down so the generator can oversample it
  always @(posedge CLK) begin
    if (!RUN) begin
      cnt_q <= 0;
      ext_q <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 0;
      ext_q <= ~ext_q;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end

  // Resonator swings the crystal pin in antiphase; external clock leaves it low
  assign EXT_PIN  = ext_q;
  assign CRYSTAL_PIN_PIN = CRYSTAL_PIN_MODE ? ~ext_q : 1'b0;
endmodule : pcg_osc_model
